/* hw/cxd_alu.sv */
/*
 combinational arithmetic and logic unit for the execution datapath.
 assumes operands are valid for the requested operation; shifts done iteratively elsewhere.
*/
`timescale 1ns/1ps
module cxd_alu
(
   input wire cxd_pkg::cxd_op_type op,
   input wire logic isWord,
   input wire logic [15:0] opA,
   input wire logic [15:0] opB,
   input wire logic [15:0] flagsIn,
   output logic [15:0] result,
   output logic writeBack,
   output logic [15:0] flagsOut
);
   logic [16:0] sum;
   logic carryOut;
   logic auxOut;
   logic ovfOut;
   logic [15:0] res;
   logic arith;
   logic [7:0] lowNib;

   function automatic logic msbOf(input logic [15:0] v, input logic w);
      msbOf = w ? v[15] : v[7];
   endfunction

   always_comb
   begin
      sum = 17'h00000;
      res = opA;
      carryOut = flagsIn[cxd_pkg::FLAG_CARRY];
      auxOut = flagsIn[cxd_pkg::FLAG_AUX];
      ovfOut = flagsIn[cxd_pkg::FLAG_OVF];
      arith = 1'b1;
      writeBack = 1'b1;
      lowNib = 8'h00;
      case (op)
         cxd_pkg::OP_ADD, cxd_pkg::OP_ADC, cxd_pkg::OP_INC:
         begin
            sum = {1'b0, opA} + {1'b0, (op == cxd_pkg::OP_INC) ? 16'h0001 : opB}
               + {16'h0000, (op == cxd_pkg::OP_ADC) & flagsIn[cxd_pkg::FLAG_CARRY]};
            res = sum[15:0];
            if (op != cxd_pkg::OP_INC)
               carryOut = isWord ? sum[16] : (opA[8] ^ opB[8] ^ sum[8]);
            auxOut = opA[4] ^ opB[4] ^ sum[4];
            ovfOut = (msbOf(opA, isWord) == msbOf(opB, isWord)) && (msbOf(res, isWord) != msbOf(opA, isWord));
         end
         cxd_pkg::OP_SUB, cxd_pkg::OP_SBB, cxd_pkg::OP_CMP, cxd_pkg::OP_DEC, cxd_pkg::OP_NEG:
         begin
            if (op == cxd_pkg::OP_NEG)
               sum = 17'h00000 - {1'b0, opA};
            else
               sum = {1'b0, opA} - {1'b0, (op == cxd_pkg::OP_DEC) ? 16'h0001 : opB}
                  - {16'h0000, (op == cxd_pkg::OP_SBB) & flagsIn[cxd_pkg::FLAG_CARRY]};
            res = sum[15:0];
            if (op != cxd_pkg::OP_DEC)
               carryOut = isWord ? sum[16] : (opA[8] ^ opB[8] ^ sum[8]);
            auxOut = opA[4] ^ opB[4] ^ sum[4];
            ovfOut = (msbOf(opA, isWord) != msbOf(opB, isWord)) && (msbOf(res, isWord) != msbOf(opA, isWord));
            writeBack = (op != cxd_pkg::OP_CMP);
         end
         cxd_pkg::OP_AAA, cxd_pkg::OP_AAS:
         begin
            // unpacked: one digit per byte, adjust carries into high byte when isWord; byte mode keeps the opA high byte
            if ((opA[3:0] > 4'h9) || flagsIn[cxd_pkg::FLAG_AUX])
            begin
               lowNib = (op == cxd_pkg::OP_AAA) ? opA[7:0] + 8'h06 : opA[7:0] - 8'h06;
               res = {(op == cxd_pkg::OP_AAA) ? opA[15:8] + 8'h01 : opA[15:8] - 8'h01, 4'h0, lowNib[3:0]};
               carryOut = 1'b1;
               auxOut = 1'b1;
            end
            else
            begin
               res = {opA[15:8], 4'h0, opA[3:0]};
               carryOut = 1'b0;
               auxOut = 1'b0;
            end
         end
         cxd_pkg::OP_DAA, cxd_pkg::OP_DAS:
         begin
            // packed: two digits per byte
            lowNib = opA[7:0];
            auxOut = (opA[3:0] > 4'h9) || flagsIn[cxd_pkg::FLAG_AUX];
            carryOut = (opA[7:0] > 8'h99) || flagsIn[cxd_pkg::FLAG_CARRY];
            if (auxOut)
               lowNib = (op == cxd_pkg::OP_DAA) ? lowNib + 8'h06 : lowNib - 8'h06;
            if (carryOut)
               lowNib = (op == cxd_pkg::OP_DAA) ? lowNib + 8'h60 : lowNib - 8'h60;
            res = {opA[15:8], lowNib};
         end
         cxd_pkg::OP_AAM:
         begin
            res = {opA[7:0] / 8'h0a, opA[7:0] % 8'h0a};
            arith = 1'b0;
         end
         cxd_pkg::OP_AAD:
         begin
            lowNib = 8'(opA[15:8] * 8'h0a) + opA[7:0];
            res = {8'h00, lowNib};
            arith = 1'b0;
         end
         cxd_pkg::OP_NOT:
         begin
            res = ~opA;
            writeBack = 1'b1;
         end
         cxd_pkg::OP_AND, cxd_pkg::OP_OR, cxd_pkg::OP_XOR, cxd_pkg::OP_TEST:
         begin
            res = (op == cxd_pkg::OP_OR) ? (opA | opB) : (op == cxd_pkg::OP_XOR) ? (opA ^ opB) : (opA & opB);
            carryOut = 1'b0;
            ovfOut = 1'b0;
            writeBack = (op != cxd_pkg::OP_TEST);
         end
         default:
         begin
            arith = 1'b0;
         end
      endcase
      if (!isWord)
         res = {opA[15:8], res[7:0]};
      result = res;
      flagsOut = flagsIn;
      if (op != cxd_pkg::OP_NOT && (arith || op == cxd_pkg::OP_AAM || op == cxd_pkg::OP_AAD))
      begin
         flagsOut[cxd_pkg::FLAG_CARRY] = carryOut;
         flagsOut[cxd_pkg::FLAG_AUX] = auxOut;
         flagsOut[cxd_pkg::FLAG_OVF] = ovfOut;
         flagsOut[cxd_pkg::FLAG_ZERO] = isWord ? (res == 16'h0000) : (res[7:0] == 8'h00);
         flagsOut[cxd_pkg::FLAG_SIGN] = msbOf(res, isWord);
         flagsOut[cxd_pkg::FLAG_PARITY] = ~^res[7:0];
      end
   end
endmodule

/* hw/cxd_datapath.sv */
/*
 execution datapath: data moves, port and flag transfer, stack steps, arithmetic,
 logic, multi-position shifts and repeated string element control.
 assumes the bus unit performs the memory and port cycles named by the outputs,
 and holds a request stable from start until done.
*/
// Function
// - moves bytes and words; port byte uses low accumulator, word uses full word
// - binary arithmetic on 8 or 16 bit signed and unsigned operands
// - packed decimal adjust for add, subtract; unpacked for add, subtract, multiply, divide
// - arithmetic results recorded in six status flags
// - complement, and, or, exclusive or on bytes or words
// - flag-only compare updates flags from and, operands unchanged
// - shift counts up to 255; logical left, right and arithmetic right
// - count from immediate field or from count byte register
// - plain rotates reinsert each bit at the opposite end
// - carry rotates treat carry as an extra operand bit
// - strings handled one byte or word element at a time, up to 64K
// - repeat prefix makes hardware repeat the string operation
// - repeated operation interruptible, resumable, stops on termination condition
// - source element in data segment unless overridden
// - destination element always in extra segment
// - source offset from source index, updated before next element
// - destination offset from destination index, updated before next element
// - direction flag 0 increments indexes, 1 decrements
// - step one for bytes, two for words
// - push and pop always move a full word
// - low flags to high accumulator, load back, push and pop flags word
// - push decrements pointer by 2 then writes; pop reads then adds 2
// - repeat decrements counter per repetition; zero count skips the operation
`timescale 1ns/1ps
module cxd_datapath
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic start,
   input wire cxd_pkg::cxd_req_type req,
   input wire logic repeatPrefix,
   input wire logic segOverride,
   input wire logic [1:0] segOverrideSel,
   input wire logic stopCond,
   input wire logic interruptReq,
   input wire logic elemDone,
   input wire logic [15:0] busReadData,
   output logic done,
   output logic busy,
   output logic suspended,
   output cxd_pkg::cxd_res_type res,
   output logic [15:0] accumulator_word,
   output logic [15:0] stackPointer,
   output logic [15:0] srcIndex,
   output logic [15:0] destination_index_reg,
   output logic [15:0] repeat_counter,
   output logic [15:0] flags,
   output logic [1:0] srcSeg,
   output logic [1:0] dstSeg,
   output logic portWord,
   output logic [15:0] stackAddr
);
   // ****************************************
   // state
   // ****************************************
   cxd_pkg::cxd_state_type state_q, state_d;
   logic [15:0] acc_q, acc_d;
   logic [15:0] sp_q, sp_d;
   logic [15:0] si_q, si_d;
   logic [15:0] di_q, di_d;
   logic [15:0] cx_q, cx_d;
   logic [15:0] flags_q, flags_d;
   logic [15:0] shVal_q, shVal_d;
   logic [7:0] shCnt_q, shCnt_d;
   logic shifting_q, shifting_d;
   logic susp_q, susp_d;
   cxd_pkg::cxd_res_type res_q, res_d;
   logic done_q, done_d;
   logic [15:0] stAddr_q, stAddr_d;

   logic [15:0] aluRes;
   logic aluWb;
   logic [15:0] aluFlags;
   logic [15:0] shOut;
   logic shCarry;
   logic [15:0] step;
   logic isShift;
   logic [7:0] countSel;

   // ****************************************
   // units
   // ****************************************
   cxd_alu u_alu
   (
      .op(req.op),
      .isWord(req.isWord),
      .opA(req.opA),
      .opB(req.opB),
      .flagsIn(flags_q),
      .result(aluRes),
      .writeBack(aluWb),
      .flagsOut(aluFlags)
   );

   cxd_shifter u_shifter
   (
      .op(req.op),
      .isWord(req.isWord),
      .valIn(shVal_q),
      .carryIn(flags_q[cxd_pkg::FLAG_CARRY]),
      .valOut(shOut),
      .carryOut(shCarry)
   );

   function automatic logic [15:0] idxNext(input logic [15:0] idx, input logic [15:0] st, input logic dir);
      // 16-bit add keeps the update inside the segment
      idxNext = dir ? (idx - st) : (idx + st);
   endfunction

   // ****************************************
   // next-state logic
   // ****************************************
   always_comb
   begin
      state_d = state_q;
      acc_d = acc_q;
      sp_d = sp_q;
      si_d = si_q;
      di_d = di_q;
      cx_d = cx_q;
      flags_d = flags_q;
      shVal_d = shVal_q;
      shCnt_d = shCnt_q;
      shifting_d = shifting_q;
      susp_d = susp_q;
      res_d = res_q;
      done_d = 1'b0;
      stAddr_d = stAddr_q;
      step = req.isWord ? cxd_pkg::STEP_WORD : cxd_pkg::STEP_BYTE;
      isShift = (req.op >= cxd_pkg::OP_SHL) && (req.op <= cxd_pkg::OP_RCR);
      countSel = req.countFromReg ? cx_q[7:0] : req.immCount;
      case (state_q)
         cxd_pkg::ST_IDLE:
         begin
            if (start)
            begin
               res_d.writeBack = 1'b1;
               res_d.flags = flags_q;
               res_d.result = req.opA;
               case (req.op)
                  cxd_pkg::OP_MOV:
                     res_d.result = req.opB;
                  cxd_pkg::OP_IN:
                     acc_d = req.isWord ? busReadData : {acc_q[15:8], busReadData[7:0]};
                  cxd_pkg::OP_OUT:
                     res_d.result = req.isWord ? acc_q : {8'h00, acc_q[7:0]};
                  cxd_pkg::OP_PUSH, cxd_pkg::OP_PUSHF:
                  begin
                     sp_d = sp_q - cxd_pkg::STACK_STEP;
                     stAddr_d = sp_q - cxd_pkg::STACK_STEP;
                     res_d.result = (req.op == cxd_pkg::OP_PUSHF) ? flags_q : req.opA;
                  end
                  cxd_pkg::OP_POP, cxd_pkg::OP_POPF:
                  begin
                     stAddr_d = sp_q;
                     sp_d = sp_q + cxd_pkg::STACK_STEP;
                     res_d.result = busReadData;
                     if (req.op == cxd_pkg::OP_POPF)
                        flags_d = busReadData & cxd_pkg::FLAG_ALL_MASK;
                  end
                  cxd_pkg::OP_FLAGS_TO_ACC_HIGH:
                     acc_d = {flags_q[7:0] & cxd_pkg::FLAG_LOW_MASK[7:0], acc_q[7:0]};
                  cxd_pkg::OP_ACC_HIGH_TO_FLAGS:
                     flags_d = {flags_q[15:8], acc_q[15:8] & cxd_pkg::FLAG_LOW_MASK[7:0]};
                  cxd_pkg::OP_STR:
                  begin
                     if (repeatPrefix && cx_q == 16'h0000)
                        state_d = cxd_pkg::ST_IDLE;
                     else
                        state_d = cxd_pkg::ST_ELEM;
                     susp_d = 1'b0;
                  end
                  default:
                  begin
                     if (isShift)
                     begin
                        shVal_d = req.opA;
                        shCnt_d = countSel;
                        shifting_d = (countSel != 8'h00);
                     end
                     else
                     begin
                        res_d.result = aluRes;
                        res_d.writeBack = aluWb;
                        res_d.flags = aluFlags;
                        flags_d = aluFlags;
                     end
                  end
               endcase
               if (isShift && countSel != 8'h00)
                  state_d = cxd_pkg::ST_STEP;
               else if (req.op != cxd_pkg::OP_STR || (repeatPrefix && cx_q == 16'h0000))
                  done_d = 1'b1;
            end
         end
         cxd_pkg::ST_STEP:
         begin
            // one position per cycle keeps the barrel small at the cost of latency
            shVal_d = shOut;
            flags_d[cxd_pkg::FLAG_CARRY] = shCarry;
            shCnt_d = shCnt_q - 8'h01;
            if (shCnt_q == 8'h01)
            begin
               shifting_d = 1'b0;
               res_d.result = req.isWord ? shOut : {req.opA[15:8], shOut[7:0]};
               res_d.flags = flags_d;
               res_d.writeBack = 1'b1;
               done_d = 1'b1;
               state_d = cxd_pkg::ST_IDLE;
            end
         end
         cxd_pkg::ST_ELEM:
         begin
            if (elemDone)
            begin
               si_d = idxNext(si_q, step, flags_q[cxd_pkg::FLAG_DIR]);
               di_d = idxNext(di_q, step, flags_q[cxd_pkg::FLAG_DIR]);
               if (repeatPrefix)
                  cx_d = cx_q - 16'h0001;
               if (!repeatPrefix || cx_d == 16'h0000 || stopCond)
               begin
                  done_d = 1'b1;
                  state_d = cxd_pkg::ST_IDLE;
               end
               else if (interruptReq)
               begin
                  // registers already advanced, so a restart resumes at the next element
                  susp_d = 1'b1;
                  done_d = 1'b1;
                  state_d = cxd_pkg::ST_IDLE;
               end
               else
                  state_d = cxd_pkg::ST_ELEM;
            end
         end
         default:
            state_d = cxd_pkg::ST_IDLE;
      endcase
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         state_q <= cxd_pkg::ST_IDLE;
         acc_q <= cxd_pkg::RESET_WORD;
         sp_q <= cxd_pkg::RESET_STACK;
         si_q <= cxd_pkg::RESET_WORD;
         di_q <= cxd_pkg::RESET_WORD;
         cx_q <= cxd_pkg::RESET_WORD;
         flags_q <= cxd_pkg::RESET_WORD;
         shVal_q <= cxd_pkg::RESET_WORD;
         shCnt_q <= 8'h00;
         shifting_q <= 1'b0;
         susp_q <= 1'b0;
         res_q <= '0;
         done_q <= 1'b0;
         stAddr_q <= cxd_pkg::RESET_WORD;
      end
      else
      begin
         state_q <= state_d;
         acc_q <= acc_d;
         sp_q <= sp_d;
         si_q <= si_d;
         di_q <= di_d;
         cx_q <= cx_d;
         flags_q <= flags_d;
         shVal_q <= shVal_d;
         shCnt_q <= shCnt_d;
         shifting_q <= shifting_d;
         susp_q <= susp_d;
         res_q <= res_d;
         done_q <= done_d;
         stAddr_q <= stAddr_d;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign done = done_q;
   assign busy = (state_q != cxd_pkg::ST_IDLE);
   assign suspended = susp_q;
   assign res = res_q;
   assign accumulator_word = acc_q;
   assign stackPointer = sp_q;
   assign srcIndex = si_q;
   assign destination_index_reg = di_q;
   assign repeat_counter = cx_q;
   assign flags = flags_q;
   assign srcSeg = segOverride ? segOverrideSel : cxd_pkg::SEG_DATA;
   assign dstSeg = cxd_pkg::SEG_EXTRA;
   assign portWord = req.isWord;
   assign stackAddr = stAddr_q;

   // ****************************************
   // checks
   // ****************************************
   property p_push_step;
      @(posedge core_clk) disable iff (rst)
      (state_q == cxd_pkg::ST_IDLE && start && req.op == cxd_pkg::OP_PUSH) |=> (sp_q == $past(sp_q) - 16'h0002);
   endproperty
   a_push_step: assert property (p_push_step) else $error("push did not lower pointer by two");

   property p_idx_step;
      @(posedge core_clk) disable iff (rst)
      (state_q == cxd_pkg::ST_ELEM && elemDone && !flags_q[cxd_pkg::FLAG_DIR])
         |=> (si_q == $past(si_q) + ($past(req.isWord) ? 16'h0002 : 16'h0001));
   endproperty
   a_idx_step: assert property (p_idx_step) else $error("source index step wrong");

   property p_zero_skip;
      @(posedge core_clk) disable iff (rst)
      (state_q == cxd_pkg::ST_IDLE && start && req.op == cxd_pkg::OP_STR && repeatPrefix && cx_q == 16'h0000)
         |=> (done && state_q == cxd_pkg::ST_IDLE && cx_q == 16'h0000);
   endproperty
   a_zero_skip: assert property (p_zero_skip) else $error("zero count did not skip");

   property p_dst_seg;
      @(posedge core_clk) disable iff (rst)
      busy |-> dstSeg == cxd_pkg::SEG_EXTRA;
   endproperty
   a_dst_seg: assert property (p_dst_seg) else $error("destination segment changed");

   property p_pop_step;
      @(posedge core_clk) disable iff (rst)
      (state_q == cxd_pkg::ST_IDLE && start && req.op == cxd_pkg::OP_POP)
         |=> (sp_q == $past(sp_q) + 16'h0002 && stAddr_q == $past(sp_q));
   endproperty
   a_pop_step: assert property (p_pop_step) else $error("pop did not read top then raise pointer by two");

   property p_idx_dec;
      @(posedge core_clk) disable iff (rst)
      (state_q == cxd_pkg::ST_ELEM && elemDone && flags_q[cxd_pkg::FLAG_DIR])
         |=> (di_q == $past(di_q) - ($past(req.isWord) ? 16'h0002 : 16'h0001));
   endproperty
   a_idx_dec: assert property (p_idx_dec) else $error("destination index did not count down");
endmodule

/* hw/cxd_pkg.sv */
/*
 execution datapath package: operation codes, flag layout, carriers and constants.
 assumes a 16-bit core where the bus unit supplies operands and takes results.
*/
package cxd_pkg;
   // ****************************************
   // widths and constants
   // ****************************************
   localparam int WORD_W = 16;
   localparam int BYTE_W = 8;
   localparam logic [15:0] STEP_BYTE = 16'h0001;
   localparam logic [15:0] STEP_WORD = 16'h0002;
   localparam logic [15:0] STACK_STEP = 16'h0002;
   localparam logic [7:0] MAX_SHIFT = 8'hff;
   localparam logic [15:0] RESET_WORD = 16'h0000;
   localparam logic [15:0] RESET_STACK = 16'h0000;
   localparam logic [1:0] SEG_DATA = 2'h3;
   localparam logic [1:0] SEG_EXTRA = 2'h0;

   // ****************************************
   // flag word bit positions
   // ****************************************
   localparam int FLAG_CARRY = 0;
   localparam int FLAG_PARITY = 2;
   localparam int FLAG_AUX = 4;
   localparam int FLAG_ZERO = 6;
   localparam int FLAG_SIGN = 7;
   localparam int FLAG_DIR = 10;
   localparam int FLAG_OVF = 11;
   localparam logic [15:0] FLAG_LOW_MASK = 16'h00d5;
   localparam logic [15:0] FLAG_ALL_MASK = 16'h0fd5;

   // ****************************************
   // operation codes
   // ****************************************
   typedef enum logic [5:0] {
      OP_NOP = 6'h00, OP_MOV = 6'h01, OP_IN = 6'h02, OP_OUT = 6'h03,
      OP_ADD = 6'h04, OP_ADC = 6'h05, OP_SUB = 6'h06, OP_SBB = 6'h07,
      OP_CMP = 6'h08, OP_INC = 6'h09, OP_DEC = 6'h0a, OP_NEG = 6'h0b,
      OP_AAA = 6'h0c, OP_DAA = 6'h0d, OP_AAS = 6'h0e, OP_DAS = 6'h0f,
      OP_AAM = 6'h10, OP_AAD = 6'h11, OP_NOT = 6'h12, OP_AND = 6'h13,
      OP_OR = 6'h14, OP_XOR = 6'h15, OP_TEST = 6'h16, OP_SHL = 6'h17,
      OP_SHR = 6'h18, OP_SAR = 6'h19, OP_ROL = 6'h1a, OP_ROR = 6'h1b,
      OP_RCL = 6'h1c, OP_RCR = 6'h1d, OP_PUSH = 6'h1e, OP_POP = 6'h1f,
      OP_FLAGS_TO_ACC_HIGH = 6'h20, OP_ACC_HIGH_TO_FLAGS = 6'h21, OP_PUSHF = 6'h22, OP_POPF = 6'h23,
      OP_STR = 6'h24
   } cxd_op_type;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ELEM = 2'b01,
      ST_STEP = 2'b11
   } cxd_state_type;

   // ****************************************
   // carriers
   // ****************************************
   typedef struct packed {
      cxd_op_type op;
      logic isWord;
      logic countFromReg;
      logic [7:0] immCount;
      logic [15:0] opA;
      logic [15:0] opB;
   } cxd_req_type;

   typedef struct packed {
      logic [15:0] result;
      logic writeBack;
      logic [15:0] flags;
   } cxd_res_type;
endpackage

/* hw/cxd_shifter.sv */
/*
 one-position shift and rotate step, iterated by the datapath control.
 assumes a stepping control that applies it once per remaining count.
*/
`timescale 1ns/1ps
module cxd_shifter
(
   input wire cxd_pkg::cxd_op_type op,
   input wire logic isWord,
   input wire logic [15:0] valIn,
   input wire logic carryIn,
   output logic [15:0] valOut,
   output logic carryOut
);
   logic msb;
   logic [15:0] v;

   always_comb
   begin
      msb = isWord ? valIn[15] : valIn[7];
      v = valIn;
      carryOut = carryIn;
      case (op)
         cxd_pkg::OP_SHL, cxd_pkg::OP_ROL, cxd_pkg::OP_RCL:
         begin
            carryOut = msb;
            v = {valIn[14:0], 1'b0};
            if (op == cxd_pkg::OP_ROL)
               v[0] = msb;
            if (op == cxd_pkg::OP_RCL)
               v[0] = carryIn;
         end
         cxd_pkg::OP_SHR, cxd_pkg::OP_SAR, cxd_pkg::OP_ROR, cxd_pkg::OP_RCR:
         begin
            carryOut = valIn[0];
            v = {1'b0, valIn[15:1]};
            if (!isWord)
               v[7] = 1'b0;
            if (op == cxd_pkg::OP_SAR)
               v[isWord ? 15 : 7] = msb;
            if (op == cxd_pkg::OP_ROR)
               v[isWord ? 15 : 7] = valIn[0];
            if (op == cxd_pkg::OP_RCR)
               v[isWord ? 15 : 7] = carryIn;
         end
         default:
         begin
            v = valIn;
         end
      endcase
      valOut = isWord ? v : {8'h00, v[7:0]};
   end
endmodule

/* tb/cxd_bus_model.sv */
/*
 bus unit stand-in: returns read data and ends string elements.
 assumes the bench sets the read value before each start.
*/
`timescale 1ns/1ps
module cxd_bus_model
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic busy,
   input wire logic [15:0] readVal,
   output logic [15:0] busReadData,
   output logic elemDone
);
   logic [1:0] cnt_q;
   // slow answer: one element every four busy cycles
   assign busReadData = readVal;
   assign elemDone = (cnt_q == 2'h3);
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         cnt_q <= 2'h0;
      end
      else
      begin
         cnt_q <= busy ? cnt_q + 2'h1 : 2'h0;
      end
   end
endmodule

/* tb/tb.sv */
/*
 bench for the execution datapath: op sequences with expected results.
 assumes the bus model answers reads and string elements.
*/
`timescale 1ns/1ps
module tb;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic start = 1'b0;
   logic repeatPrefix = 1'b0;
   logic segOverride = 1'b0;
   logic [1:0] segOverrideSel = 2'h1;
   logic elemDone, done, busy, portWord;
   logic [15:0] busReadData, accW, sp, si, di, cx, flags, sAddr;
   logic [15:0] busVal = 16'h0000;
   logic [1:0] srcSeg, dstSeg;
   cxd_pkg::cxd_req_type req = '0;
   cxd_pkg::cxd_res_type res;
   int fail_count = 0;
   int check_count = 0;
   always #12.5 core_clk = ~core_clk;
   cxd_bus_model bus (.core_clk(core_clk), .rst(rst), .busy(busy), .readVal(busVal),
      .busReadData(busReadData), .elemDone(elemDone));
   cxd_datapath uut (.core_clk(core_clk), .rst(rst), .start(start), .req(req),
      .repeatPrefix(repeatPrefix), .segOverride(segOverride), .segOverrideSel(segOverrideSel),
      .stopCond(1'b0), .interruptReq(1'b0), .elemDone(elemDone), .busReadData(busReadData),
      .done(done), .busy(busy), .suspended(), .res(res), .accumulator_word(accW),
      .stackPointer(sp), .srcIndex(si), .destination_index_reg(di), .repeat_counter(cx),
      .flags(flags), .srcSeg(srcSeg), .dstSeg(dstSeg), .portWord(portWord), .stackAddr(sAddr));
   // ****************************************
   // tasks
   // ****************************************
   task chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task run(input cxd_pkg::cxd_op_type op, input logic w, input logic c, input logic [7:0] n,
      input logic [15:0] a);
      int i;
      @(negedge core_clk);
      req = '{op: op, isWord: w, countFromReg: c, immCount: n, opA: a, opB: 16'h00f0};
      start = 1'b1;
      @(negedge core_clk);
      start = 1'b0;
      i = 0;
      while (done !== 1'b1 && i < 400)
      begin
         @(posedge core_clk);
         #1;
         i++;
      end
      chk({15'h0, done}, 16'h0001);
   endtask
   task give_verdict;
      if (fail_count == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      #500000;
      fail_count++;
      give_verdict;
   end
   initial
   begin
      repeat (16) @(negedge core_clk);
      rst = 1'b0;
      chk(sp, cxd_pkg::RESET_STACK);
      run(cxd_pkg::OP_ADD, 1'b0, 1'b0, 8'h00, 16'h12f0);
      chk(res.result, 16'h12e0);
      chk({15'h0, flags[cxd_pkg::FLAG_CARRY]}, 16'h0001);
      run(cxd_pkg::OP_AND, 1'b1, 1'b0, 8'h00, 16'hf0f0);
      chk(res.result, 16'h00f0);
      run(cxd_pkg::OP_TEST, 1'b1, 1'b0, 8'h00, 16'h000f);
      chk({15'h0, res.writeBack}, 16'h0000);
      chk({15'h0, flags[cxd_pkg::FLAG_ZERO]}, 16'h0001);
      run(cxd_pkg::OP_SHL, 1'b0, 1'b0, 8'h03, 16'h0081);
      chk(res.result, 16'h0008);
      run(cxd_pkg::OP_SAR, 1'b0, 1'b0, 8'h01, 16'h0080);
      chk(res.result, 16'h00c0);
      run(cxd_pkg::OP_ROL, 1'b1, 1'b0, 8'h04, 16'h1234);
      chk(res.result, 16'h2341);
      // nine steps through carry bring a byte back whatever carry held
      run(cxd_pkg::OP_RCL, 1'b0, 1'b0, 8'h09, 16'h005a);
      chk(res.result, 16'h005a);
      run(cxd_pkg::OP_ROL, 1'b1, 1'b1, 8'h04, 16'h1234);
      chk(res.result, 16'h1234);
      busVal = 16'hbeef;
      run(cxd_pkg::OP_IN, 1'b1, 1'b0, 8'h00, 16'h0000);
      chk(accW, 16'hbeef);
      chk({15'h0, portWord}, 16'h0001);
      run(cxd_pkg::OP_PUSH, 1'b1, 1'b0, 8'h00, 16'h1111);
      chk(sp, 16'hfffe);
      chk(sAddr, 16'hfffe);
      busVal = 16'h5a5a;
      run(cxd_pkg::OP_POP, 1'b1, 1'b0, 8'h00, 16'h0000);
      chk(res.result, 16'h5a5a);
      chk(sp, 16'h0000);
      chk({14'h0, srcSeg}, {14'h0, cxd_pkg::SEG_DATA});
      segOverride = 1'b1;
      #1;
      chk({14'h0, srcSeg}, 16'h0001);
      chk({14'h0, dstSeg}, {14'h0, cxd_pkg::SEG_EXTRA});
      repeatPrefix = 1'b1;
      run(cxd_pkg::OP_STR, 1'b1, 1'b0, 8'h00, 16'h0000);
      chk(si, 16'h0000);
      chk(di, 16'h0000);
      chk(cx, 16'h0000);
      repeatPrefix = 1'b0;
      run(cxd_pkg::OP_STR, 1'b1, 1'b0, 8'h00, 16'h0000);
      chk(si, 16'h0002);
      chk(di, 16'h0002);
      busVal = 16'h0400;
      run(cxd_pkg::OP_POPF, 1'b1, 1'b0, 8'h00, 16'h0000);
      chk(flags, 16'h0400);
      run(cxd_pkg::OP_FLAGS_TO_ACC_HIGH, 1'b0, 1'b0, 8'h00, 16'h0000);
      chk(accW, 16'h00ef);
      run(cxd_pkg::OP_DAA, 1'b0, 1'b0, 8'h00, 16'h000f);
      chk(res.result, 16'h0015);
      run(cxd_pkg::OP_STR, 1'b0, 1'b0, 8'h00, 16'h0000);
      chk(si, 16'h0001);
      chk(di, 16'h0001);
      give_verdict;
   end
endmodule
